// [logic/fpd_map.svh]
`ifndef FPD_MAP_SVH
`define FPD_MAP_SVH
// Contract
// [RULE1] Bound register reports highest FIFO RAM address
// [RULE2] Start/bound reserved bits zero, bit 10 one
// [RULE3] Transmit FIFO spans tx start to rx start-4
// [RULE4] Receive FIFO spans rx start to bound
// [RULE5] Enabling loads default receive start address
// [RULE6] Receive start field splits tx and rx
// [RULE7] Transmit starts at threshold, end-of-frame or full
// [RULE8] Threshold: 0x=64, 10=128, 11=192 bytes
// [RULE9] Transmit start resets to first free address
// [RULE10] Software never sets tx start below reset
// [RULE11] Payload byte order driven to DMA port
// [RULE12] Descriptor byte order driven to DMA port
// [RULE13] Function code driven on every DMA transfer
// [RULE14] Attribute reserved bits 0-23 and 31 read zero
// [RULE15] Enabling resets FIFO pointers before activation
// [RULE16] FIFO addresses are whole 32-bit words

// ============================================================
// Register offsets
`define FPD_OFF_STAT  12'hEC4
`define FPD_OFF_CTRL  12'hEC8
`define FPD_OFF_BOUND 12'hECC
`define FPD_OFF_RXS   12'hED0
`define FPD_OFF_TXS   12'hEEC
`define FPD_OFF_ATTR  12'hF34

// ============================================================
// Field positions
`define FPD_FLD_MSB   9
`define FPD_FLD_LSB   2
`define FPD_FIX_BIT   10
`define FPD_THR_MSB   1
`define FPD_THR_LSB   0
`define FPD_ATTR_MSB  30
`define FPD_ATTR_LSB  24
`define FPD_EN_BIT    0
`define FPD_ST_RXC    16
`define FPD_ST_ACT    30
`define FPD_ST_GO     31

// ============================================================
// Reset and default values
`define FPD_BOUND_DEF 8'hFF
`define FPD_RXS_DEF   8'h80
`define FPD_TXS_RST   8'h00

// ============================================================
// Threshold sizes
`define FPD_THR_LO    64
`define FPD_THR_MID   128
`define FPD_THR_HI    192
`define FPD_WORD_B    4
`endif

// [logic/fpd_pkg.sv]
`default_nettype none
package fpd_pkg;
    typedef logic [31:0] fpd_data_t;
    typedef logic [11:0] fpd_addr_t;
    typedef logic [7:0]  fpd_word_t;
    typedef logic [1:0]  fpd_bo_t;
    typedef logic [2:0]  fpd_fc_t;

    typedef struct packed {
        logic                   pready;
        logic                   pslverr;
        fpd_data_t              prdata;
        logic                   enable;
        logic                   active;
        logic                   slot;
        fpd_word_t              rxs;
        fpd_word_t              txs;
        logic [1:0]             thr;
        logic [6:0]             attr;
        fpd_word_t              txw;
        fpd_word_t              txr;
        fpd_word_t              rxw;
        fpd_word_t              rxr;
        logic [8:0]             txc;
        logic [8:0]             rxc;
        logic                   tx_go;
        logic                   dtx_rdy;
        logic                   mrx_rdy;
        logic [1:0]             infl;
        logic [1:0][1:0]        bv;
        logic [1:0][1:0][31:0]  bd;
    } fpd_st_t;
endpackage
`default_nettype wire

// [logic/fpd_ram.sv]
`timescale 1ns/1ps
`default_nettype none
module fpd_ram #(
    parameter int AW = 8,
    parameter int DW = 32
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] wa,
    input  wire logic [DW-1:0] wd,
    input  wire logic          re,
    input  wire logic [AW-1:0] ra,
    output var  logic [DW-1:0] rd_q
);
    // ============================================================
    // Storage, registered read
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[wa] <= wd;
        end
        if (re) begin
            rd_q <= mem[ra];
        end
    end
endmodule
`default_nettype wire

// [logic/fpd_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fpd_map.svh"
module fpd_top #(
    parameter logic [7:0] BOUND_WORD = `FPD_BOUND_DEF,
    parameter logic [7:0] RXS_DEF    = `FPD_RXS_DEF,
    parameter logic [7:0] TXS_RESET  = `FPD_TXS_RST
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire fpd_pkg::fpd_addr_t paddr,
    input  wire fpd_pkg::fpd_data_t pwdata,
    output var  fpd_pkg::fpd_data_t prdata,
    output var  logic               pready,
    output var  logic               pslverr,
    input  wire logic               dma_tx_valid,
    input  wire fpd_pkg::fpd_data_t dma_tx_data,
    input  wire logic               dma_tx_last,
    output var  logic               dma_tx_ready,
    output var  logic               mac_tx_valid,
    output var  fpd_pkg::fpd_data_t mac_tx_data,
    input  wire logic               mac_tx_ready,
    output var  logic               tx_start,
    input  wire logic               mac_rx_valid,
    input  wire fpd_pkg::fpd_data_t mac_rx_data,
    output var  logic               mac_rx_ready,
    output var  logic               dma_rx_valid,
    output var  fpd_pkg::fpd_data_t dma_rx_data,
    input  wire logic               dma_rx_ready,
    output var  fpd_pkg::fpd_bo_t   payload_byte_order,
    output var  fpd_pkg::fpd_bo_t   descriptor_byte_order,
    output var  fpd_pkg::fpd_fc_t   bus_function_code,
    output var  logic               controller_active
);
    import fpd_pkg::*;

    // ============================================================
    // Helpers
    function automatic logic [7:0] nxt(input logic [7:0] p, input logic [7:0] lo,
                                        input logic [7:0] hi);
        return (p == hi) ? lo : 8'(p + 8'h01);
    endfunction

    function automatic logic [8:0] thr_words(input logic [1:0] t);
        if (!t[1]) begin
            return 9'(`FPD_THR_LO / `FPD_WORD_B);
        end else if (!t[0]) begin
            return 9'(`FPD_THR_MID / `FPD_WORD_B);
        end
        return 9'(`FPD_THR_HI / `FPD_WORD_B);
    endfunction

    function automatic logic [31:0] fld_word(input logic [7:0] f);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`FPD_FIX_BIT] = 1'b1;
        w[`FPD_FLD_MSB:`FPD_FLD_LSB] = f;
        return w;
    endfunction

    // Word-granular starts: the field holds a word index, low bits implied zero
    localparam fpd_st_t ST_RST = '{txs: TXS_RESET, default: '0};

    fpd_st_t     s_q;
    fpd_st_t     s_d;
    logic        ram_we;
    logic [7:0]  ram_wa;
    logic [31:0] ram_wd;
    logic        ram_re;
    logic [7:0]  ram_ra;
    logic [31:0] ram_rd;
    logic        acc;
    logic        wr;
    logic        setup_rd;
    logic        restart;
    logic        init;
    logic        tx_wr;
    logic        rx_wr;
    logic        avail;
    logic [1:0]  outr;
    logic [8:0]  txsize;
    logic [8:0]  rxsize;

    // ============================================================
    // Next state
    always_comb begin
        s_d = s_q;
        ram_we = 1'b0;
        ram_wa = 8'h00;
        ram_wd = 32'h0000_0000;
        ram_re = 1'b0;
        ram_ra = 8'h00;
        restart = 1'b0;
        tx_wr = 1'b0;
        rx_wr = 1'b0;
        avail = 1'b0;
        outr = {dma_rx_ready, mac_tx_ready};
        acc = psel && penable && s_q.pready;
        wr = acc && pwrite;
        setup_rd = psel && !penable && !pwrite;

        // APB: one fixed wait-free access phase after setup
        s_d.pready = psel && !penable;
        s_d.pslverr = 1'b0;
        s_d.prdata = 32'h0000_0000;
        if (psel && !penable) begin
            unique case (paddr)
                `FPD_OFF_BOUND: s_d.prdata = fld_word(BOUND_WORD);        // [RULE1] [RULE2]
                `FPD_OFF_RXS: begin
                    s_d.prdata = fld_word(s_q.rxs);                        // [RULE2] [RULE6]
                    s_d.prdata[`FPD_THR_MSB:`FPD_THR_LSB] = s_q.thr;
                end
                `FPD_OFF_TXS: s_d.prdata = fld_word(s_q.txs);             // [RULE2] [RULE16]
                `FPD_OFF_ATTR: s_d.prdata[`FPD_ATTR_MSB:`FPD_ATTR_LSB] = s_q.attr; // [RULE14]
                `FPD_OFF_CTRL: s_d.prdata[`FPD_EN_BIT] = s_q.enable;
                `FPD_OFF_STAT: begin
                    s_d.prdata[8:0] = s_q.txc;
                    s_d.prdata[`FPD_ST_RXC +: 9] = s_q.rxc;
                    s_d.prdata[`FPD_ST_ACT] = s_q.active;
                    s_d.prdata[`FPD_ST_GO] = s_q.tx_go;
                end
                default: s_d.pslverr = 1'b1;
            endcase
            if (pwrite) begin
                s_d.prdata = 32'h0000_0000;
            end
        end

        if (wr) begin
            unique case (paddr)
                `FPD_OFF_CTRL: s_d.enable = pwdata[`FPD_EN_BIT];
                `FPD_OFF_RXS: begin
                    s_d.rxs = pwdata[`FPD_FLD_MSB:`FPD_FLD_LSB];           // [RULE6] [RULE16]
                    s_d.thr = pwdata[`FPD_THR_MSB:`FPD_THR_LSB];           // [RULE8]
                    restart = 1'b1;
                end
                `FPD_OFF_TXS: begin
                    s_d.txs = pwdata[`FPD_FLD_MSB:`FPD_FLD_LSB];           // [RULE16]
                    restart = 1'b1;
                end
                `FPD_OFF_ATTR: s_d.attr = pwdata[`FPD_ATTR_MSB:`FPD_ATTR_LSB]; // [RULE11] [RULE12] [RULE13]
                default: ;
            endcase
        end

        // One init cycle between enable and activation
        init = s_q.enable && !s_q.active;
        s_d.active = s_q.enable && s_d.enable;
        if (init) begin
            s_d.rxs = RXS_DEF;                                             // [RULE5]
        end
        s_d.slot = !s_q.slot;
        s_d.infl = 2'b00;

        if (init || restart || !s_q.enable) begin
            s_d.txw = s_d.txs;                                             // [RULE15]
            s_d.txr = s_d.txs;
            s_d.rxw = s_d.rxs;
            s_d.rxr = s_d.rxs;
            s_d.txc = 9'h000;
            s_d.rxc = 9'h000;
            s_d.bv = '0;
            s_d.tx_go = 1'b0;
        end else begin
            // Slots keep the single write port free of collisions, at half rate
            tx_wr = dma_tx_valid && s_q.dtx_rdy;
            rx_wr = mac_rx_valid && s_q.mrx_rdy;
            if (tx_wr) begin
                ram_we = 1'b1;
                ram_wa = s_q.txw;
                ram_wd = dma_tx_data;
                s_d.txw = nxt(s_q.txw, s_q.txs, 8'(s_q.rxs - 8'h01));      // [RULE3]
                s_d.txc = 9'(s_q.txc + 9'h001);
            end else if (rx_wr) begin
                ram_we = 1'b1;
                ram_wa = s_q.rxw;
                ram_wd = mac_rx_data;
                s_d.rxw = nxt(s_q.rxw, s_q.rxs, BOUND_WORD);               // [RULE4]
                s_d.rxc = 9'(s_q.rxc + 9'h001);
            end

            // Two-entry output buffers, path 0 to MAC, path 1 to DMA
            for (int p = 0; p < 2; p++) begin
                if (s_q.bv[p][0] && outr[p]) begin
                    s_d.bv[p][0] = s_q.bv[p][1];
                    s_d.bd[p][0] = s_q.bd[p][1];
                    s_d.bv[p][1] = 1'b0;
                end
                if (s_q.infl[p]) begin
                    if (!s_d.bv[p][0]) begin
                        s_d.bv[p][0] = 1'b1;
                        s_d.bd[p][0] = ram_rd;
                    end else begin
                        s_d.bv[p][1] = 1'b1;
                        s_d.bd[p][1] = ram_rd;
                    end
                end
            end

            // Reads use last cycle's counts, so a word is never read as it lands
            if (!s_q.slot) begin
                avail = s_q.tx_go && (s_q.txc != 9'h000) && !s_d.bv[0][1];
                if (avail) begin
                    ram_re = 1'b1;
                    ram_ra = s_q.txr;
                    s_d.infl[0] = 1'b1;
                    s_d.txr = nxt(s_q.txr, s_q.txs, 8'(s_q.rxs - 8'h01)); // [RULE3]
                    s_d.txc = 9'(s_d.txc - 9'h001);
                end
            end else begin
                avail = (s_q.rxc != 9'h000) && !s_d.bv[1][1];
                if (avail) begin
                    ram_re = 1'b1;
                    ram_ra = s_q.rxr;
                    s_d.infl[1] = 1'b1;
                    s_d.rxr = nxt(s_q.rxr, s_q.rxs, BOUND_WORD);           // [RULE4]
                    s_d.rxc = 9'(s_d.rxc - 9'h001);
                end
            end

            if (s_q.tx_go) begin
                s_d.tx_go = (s_d.txc != 9'h000);
            end else begin
                s_d.tx_go = (s_d.txc >= thr_words(s_q.thr))                // [RULE7] [RULE8]
                         || (tx_wr && dma_tx_last)
                         || (s_d.txc == 9'({1'b0, s_q.rxs} - {1'b0, s_q.txs}));
            end
        end

        // Ready is registered from the post-cycle fill, so full is never overrun
        txsize = 9'({1'b0, s_d.rxs} - {1'b0, s_d.txs});
        rxsize = 9'({1'b0, BOUND_WORD} - {1'b0, s_d.rxs} + 9'h001);
        s_d.dtx_rdy = s_d.active && !s_d.slot && (s_d.txc < txsize);
        s_d.mrx_rdy = s_d.active && s_d.slot && (s_d.rxc < rxsize);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= ST_RST;                                                 // [RULE9]
        end else begin
            s_q <= s_d;
        end
    end

    fpd_ram #(
        .AW (8),
        .DW (32)
    ) u_ram (
        .clk  (pclk),
        .we   (ram_we),
        .wa   (ram_wa),
        .wd   (ram_wd),
        .re   (ram_re),
        .ra   (ram_ra),
        .rd_q (ram_rd)
    );

    // ============================================================
    // Outputs
    assign prdata                = s_q.prdata;
    assign pready                = s_q.pready;
    assign pslverr               = s_q.pslverr;
    assign dma_tx_ready          = s_q.dtx_rdy;
    assign mac_rx_ready          = s_q.mrx_rdy;
    assign mac_tx_valid          = s_q.bv[0][0];
    assign mac_tx_data           = s_q.bd[0][0];
    assign dma_rx_valid          = s_q.bv[1][0];
    assign dma_rx_data           = s_q.bd[1][0];
    assign tx_start              = s_q.tx_go;
    assign payload_byte_order    = s_q.attr[6:5];                          // [RULE11]
    assign descriptor_byte_order = s_q.attr[4:3];                          // [RULE12]
    assign bus_function_code     = s_q.attr[2:0];                          // [RULE13]
    assign controller_active     = s_q.active;

    // ============================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_bound_read: assert property ( // [RULE1]
        (setup_rd && paddr == `FPD_OFF_BOUND)
        |=> prdata[`FPD_FLD_MSB:`FPD_FLD_LSB] == BOUND_WORD && pready)
        else $error("bound field wrong");
    a_start_rsvd: assert property ( // [RULE2]
        (setup_rd && (paddr == `FPD_OFF_TXS || paddr == `FPD_OFF_RXS))
        |=> (prdata >> `FPD_FIX_BIT) == 32'h0000_0001)
        else $error("reserved start bits wrong");
    a_word_gran: assert property ( // [RULE16]
        (setup_rd && paddr == `FPD_OFF_TXS) |=> prdata[1:0] == 2'h0)
        else $error("tx start low bits set");
    a_tx_window: assert property ( // [RULE3]
        (s_q.active && s_q.rxs > s_q.txs)
        |-> s_q.txw >= s_q.txs && s_q.txw < s_q.rxs && s_q.txr < s_q.rxs)
        else $error("tx pointer outside region");
    a_rx_window: assert property ( // [RULE4]
        (s_q.active && s_q.rxs <= BOUND_WORD) |-> s_q.rxw >= s_q.rxs && s_q.rxr >= s_q.rxs)
        else $error("rx pointer outside region");
    a_rx_default: assert property ( // [RULE5]
        (s_q.enable && !s_q.active && !(wr && paddr == `FPD_OFF_CTRL))
        |=> s_q.rxs == RXS_DEF && s_q.active)
        else $error("rx start default not loaded");
    a_init_ptrs: assert property ( // [RULE15]
        $rose(s_q.active) |-> s_q.txc == 9'h000 && s_q.rxc == 9'h000
        && s_q.txw == s_q.txs && s_q.rxr == s_q.rxs && !s_q.tx_go)
        else $error("pointers not reset before activation");
    a_thr_go: assert property ( // [RULE7]
        (s_q.active && s_q.enable && !restart && s_q.txc >= thr_words(s_q.thr))
        |=> tx_start)
        else $error("threshold reached without start");
    a_no_early: assert property ( // [RULE8]
        (s_q.active && !tx_start && !restart && !(dma_tx_valid && dma_tx_last))
        ##1 (s_q.txc < thr_words(s_q.thr) && s_q.txc < s_q.rxs - s_q.txs)
        |-> !tx_start)
        else $error("start before threshold");
    a_attr_drive: assert property ( // [RULE13]
        (wr && paddr == `FPD_OFF_ATTR)
        |=> bus_function_code == $past(pwdata[26:24])
        && payload_byte_order == $past(pwdata[30:29]))
        else $error("attributes not driven");
    a_attr_rsvd: assert property ( // [RULE14]
        (setup_rd && paddr == `FPD_OFF_ATTR) |=> prdata[23:0] == 24'h00_0000 && !prdata[31])
        else $error("attribute reserved bits set");
endmodule
`default_nettype wire

// [bench/fpd_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fpd_far_model (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               stall,
    input  wire logic               mac_tx_valid,
    input  wire fpd_pkg::fpd_data_t mac_tx_data,
    output var  logic               mac_tx_ready,
    input  wire logic               dma_rx_valid,
    input  wire fpd_pkg::fpd_data_t dma_rx_data,
    output var  logic               dma_rx_ready,
    output var  int                 n_tx,
    output var  int                 n_rx,
    output var  fpd_pkg::fpd_data_t last_tx,
    output var  fpd_pkg::fpd_data_t last_rx
);
    import fpd_pkg::*;
    // ==========================================
    // Sink for both outgoing streams
    // Stall is shared so both output buffers see back-pressure
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mac_tx_ready <= 1'b0;
            dma_rx_ready <= 1'b0;
            n_tx         <= 0;
            n_rx         <= 0;
            last_tx      <= 32'h0;
            last_rx      <= 32'h0;
        end else begin
            mac_tx_ready <= !stall;
            dma_rx_ready <= !stall;
            if (mac_tx_valid && mac_tx_ready) begin
                n_tx    <= n_tx + 1;
                last_tx <= mac_tx_data;
            end
            if (dma_rx_valid && dma_rx_ready) begin
                n_rx    <= n_rx + 1;
                last_rx <= dma_rx_data;
            end
        end
    end
endmodule
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fpd_map.svh"
module testbench;
    import fpd_pkg::*;
    logic      pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stall = 1;
    fpd_addr_t paddr = 12'h0;
    fpd_data_t pwdata = 32'h0, prdata, mac_tx_data, dma_rx_data, last_tx, last_rx;
    fpd_data_t dma_tx_data = 32'h0, mac_rx_data = 32'h0, rdv;
    logic      dma_tx_valid = 0, dma_tx_last = 0, mac_rx_valid = 0, err;
    logic      pready, pslverr, dma_tx_ready, mac_tx_valid, mac_tx_ready, tx_start;
    logic      mac_rx_ready, dma_rx_valid, dma_rx_ready, controller_active;
    fpd_bo_t   payload_byte_order, descriptor_byte_order;
    fpd_fc_t   bus_function_code;
    int        n_errors = 0, tests_run = 0, n_tx, n_rx, took, b0;

    always #20 pclk = ~pclk;

    fpd_top u_fpd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dma_tx_valid(dma_tx_valid), .dma_tx_data(dma_tx_data),
        .dma_tx_last(dma_tx_last), .dma_tx_ready(dma_tx_ready), .mac_tx_valid(mac_tx_valid),
        .mac_tx_data(mac_tx_data), .mac_tx_ready(mac_tx_ready), .tx_start(tx_start),
        .mac_rx_valid(mac_rx_valid), .mac_rx_data(mac_rx_data), .mac_rx_ready(mac_rx_ready),
        .dma_rx_valid(dma_rx_valid), .dma_rx_data(dma_rx_data), .dma_rx_ready(dma_rx_ready),
        .payload_byte_order(payload_byte_order), .descriptor_byte_order(descriptor_byte_order),
        .bus_function_code(bus_function_code), .controller_active(controller_active));

    fpd_far_model u_fpd_far_model (.pclk(pclk), .presetn(presetn), .stall(stall),
        .mac_tx_valid(mac_tx_valid), .mac_tx_data(mac_tx_data), .mac_tx_ready(mac_tx_ready),
        .dma_rx_valid(dma_rx_valid), .dma_rx_data(dma_rx_data), .dma_rx_ready(dma_rx_ready),
        .n_tx(n_tx), .n_rx(n_rx), .last_tx(last_tx), .last_rx(last_rx));

    // ==========================================
    // Shared helpers
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input fpd_data_t got, input fpd_data_t exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Slave latency is not assumed; pready is sampled where settled
    task automatic apb(input logic wr, input fpd_addr_t a, input fpd_data_t wd);
        int k;
        logic rdy;
        k = 0;
        rdy = 0;
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        while (!rdy && k < 50) begin
            @(negedge pclk);
            rdy = pready;
            rdv = prdata;
            err = pslverr;
            @(posedge pclk);
            k++;
        end
        chk(32'(rdy), 32'd1, "pready");
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask

    task automatic rd(input fpd_addr_t a, input fpd_data_t exp, input fpd_data_t m);
        apb(1'b0, a, 32'h0);
        chk(rdv & m, exp, "read");
    endtask

    // Ends early when a word waits lim cycles; took says how many went in
    task automatic push(input bit rx, input fpd_data_t b, input int n, input bit eof,
                        input int lim);
        int k;
        logic rdy;
        took = 0;
        for (int i = 0; i < n; i++) begin
            k = 0;
            rdy = 0;
            if (rx) begin
                mac_rx_valid <= 1;
                mac_rx_data <= b + i;
            end else begin
                dma_tx_valid <= 1;
                dma_tx_data <= b + i;
                dma_tx_last <= eof && (i == n - 1);
            end
            while (!rdy && k < lim) begin
                @(negedge pclk);
                rdy = rx ? mac_rx_ready : dma_tx_ready;
                @(posedge pclk);
                k++;
            end
            if (!rdy) break;
            took++;
        end
        mac_rx_valid <= 0;
        dma_tx_valid <= 0;
        dma_tx_last <= 0;
        @(posedge pclk);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        rd(`FPD_OFF_BOUND, 32'h400 | (32'(`FPD_BOUND_DEF) << 2), '1);
        apb(1'b1, `FPD_OFF_BOUND, 32'h0);
        rd(`FPD_OFF_BOUND, 32'h400 | (32'(`FPD_BOUND_DEF) << 2), '1);
        rd(`FPD_OFF_RXS, 32'h400, '1);
        rd(`FPD_OFF_TXS, 32'h400 | (32'(`FPD_TXS_RST) << 2), '1);
        rd(`FPD_OFF_ATTR, 32'h0, '1);
        apb(1'b0, 12'h000, 32'h0);
        chk(32'(err), 32'd1, "unmapped");
        $display("test reset done");
    endtask

    task automatic t_attr();
        fpd_data_t w;
        for (int i = 0; i < 4; i++) begin
            w = (32'(i) << 29) | (32'(3 - i) << 27) | (32'(i + 3) << 24) | 32'h80FFFFFF;
            apb(1'b1, `FPD_OFF_ATTR, w);
            rd(`FPD_OFF_ATTR, w & 32'h7F000000, '1);
            chk(32'(payload_byte_order), 32'(i), "payload order");
            chk(32'(descriptor_byte_order), 32'(3 - i), "descr order");
            chk(32'(bus_function_code), 32'(i + 3), "func code");
        end
        $display("test attr done");
    endtask

    task automatic t_enable();
        apb(1'b1, `FPD_OFF_TXS, 32'h400 | (32'(`FPD_TXS_RST) << 2));
        apb(1'b1, `FPD_OFF_CTRL, 32'h1);
        // Active rises on the edge the task returns at; look once it has settled
        @(negedge pclk);
        chk(32'(controller_active), 32'd1, "active");
        @(posedge pclk);
        rd(`FPD_OFF_RXS, 32'h400 | (32'(`FPD_RXS_DEF) << 2), 32'hFFFFFFFC);
        $display("test enable done");
    endtask

    task automatic t_thr();
        int w;
        for (int c = 0; c < 4; c++) begin
            w = (c < 2 ? `FPD_THR_LO : c == 2 ? `FPD_THR_MID : `FPD_THR_HI) / `FPD_WORD_B;
            stall <= 1;
            apb(1'b1, `FPD_OFF_RXS, 32'h400 | (32'(`FPD_RXS_DEF) << 2) | 32'(c));
            b0 = n_tx;
            push(0, 32'hA500_0000, w - 1, 0, 40);
            repeat (4) @(posedge pclk);
            chk(32'(tx_start), 32'd0, "below threshold");
            push(0, 32'hB600_0000, 1, 0, 40);
            repeat (3) @(posedge pclk);
            chk(32'(tx_start), 32'd1, "at threshold");
            stall <= 0;
            repeat (200) @(posedge pclk);
            chk(32'(n_tx - b0), 32'(w), "tx drained");
            chk(last_tx, 32'hB600_0000, "tx order");
        end
        $display("test threshold done");
    endtask

    task automatic t_eof_full();
        stall <= 1;
        apb(1'b1, `FPD_OFF_RXS, 32'h400 | (32'(`FPD_RXS_DEF) << 2) | 32'h3);
        push(0, 32'hC700_0000, 3, 1, 40);
        repeat (3) @(posedge pclk);
        chk(32'(tx_start), 32'd1, "end of frame");
        apb(1'b1, `FPD_OFF_RXS, 32'h400 | (32'h08 << 2) | 32'h3);
        b0 = n_tx;
        push(0, 32'hD800_0000, 20, 0, 30);
        chk(32'(took >= 8 && took <= 10), 32'd1, "tx fifo size");
        chk(32'(tx_start), 32'd1, "full start");
        stall <= 0;
        repeat (100) @(posedge pclk);
        chk(32'(n_tx - b0), 32'(took), "tx full drained");
        chk(32'(tx_start), 32'd0, "tx empty");
        $display("test eof and full done");
    endtask

    task automatic t_rx();
        stall <= 1;
        apb(1'b1, `FPD_OFF_RXS, 32'h400 | (32'h0FC << 2));
        b0 = n_rx;
        push(1, 32'hE900_0000, 20, 0, 30);
        chk(32'(took >= 4 && took <= 6), 32'd1, "rx fifo size");
        stall <= 0;
        repeat (60) @(posedge pclk);
        chk(32'(n_rx - b0), 32'(took), "rx drained");
        chk(last_rx, 32'hE900_0000 + 32'(took - 1), "rx order");
        $display("test rx done");
    endtask

    task automatic t_disable();
        apb(1'b1, `FPD_OFF_CTRL, 32'h0);
        chk(32'(controller_active), 32'd0, "inactive");
        push(1, 32'hF000_0000, 1, 0, 10);
        chk(32'(took), 32'd0, "rx refused");
        apb(1'b1, `FPD_OFF_CTRL, 32'h1);
        rd(`FPD_OFF_RXS, 32'h400 | (32'(`FPD_RXS_DEF) << 2), 32'hFFFFFFFC);
        $display("test disable done");
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_reset();
        t_attr();
        t_enable();
        t_thr();
        t_eof_full();
        t_rx();
        t_disable();
        conclude();
    end

    // Tests need about 1500 cycles; generous margin
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        $display("FAIL %0t watchdog", $time);
        conclude();
    end
endmodule
`default_nettype wire
